// ---- src/rdm_drop_pin_mux.sv ----
/*
 Drop-bus pin sharing for parity, alarm and data bit 0, with the word
 buffer that feeds the drop bus.
 Assumes all inputs, the drop clock included, are synchronous to sys_clk,
 and that the drop clock is much slower than sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module rdm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and control
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic full,
   output logic empty
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;
   logic push;
   logic pop;

   // Honest flags: ready drops only when every slot is taken
   assign full = (count_q == DEPTH_C);
   assign empty = (count_q == '0);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr_q];
   assign push = in_valid && in_ready && clk_en;
   assign pop = out_valid && out_ready && clk_en;

   // Storage has no reset; only the pointers and the count need a defined start
   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem[wr_ptr_q] <= in_data;
   end

   // Pointers wrap explicitly so a depth that is not a power of two works
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule

module rdm_drop_pin_mux #(
   parameter int NUM_BUS = rdm_pkg::NUM_BUS,
   parameter int NUM_LOWRATE = rdm_pkg::NUM_LOWRATE,
   parameter int FIFO_DEPTH = rdm_pkg::FIFO_DEPTH
) (
   // Clock, reset, freeze
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Microprocessor register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Configuration levels
   input wire logic [NUM_BUS-1:0] drop_bus_enable,
   input wire logic [NUM_LOWRATE-1:0] lowrate_sts1_mode,
   input wire logic parity_odd_sel,
   input wire logic parity_cover_ind,
   // Low-rate frame pulses
   input wire logic [NUM_LOWRATE-1:0] egress_lowrate_frame_pulse,
   input wire logic [NUM_LOWRATE-1:0] tx_lowrate_sonet_frame_pulse,
   // Byte stream source, one lane per bus channel
   input wire logic src_valid,
   output logic src_ready,
   input wire logic [NUM_BUS*8-1:0] src_data,
   input wire logic [NUM_BUS-1:0] src_payload,
   input wire logic [NUM_BUS-1:0] src_c1j1,
   input wire logic [NUM_BUS-1:0] src_ais,
   // Drop bus pins
   input wire logic drop_bus_clock_ch0,
   output logic [7:0] drop_bus_data_ch0,
   output logic [NUM_BUS-1:0] drop_bus_parity_out,
   output logic [NUM_BUS-1:0] drop_bus_alarm_out
);
   localparam int FW = NUM_BUS * 11;

   logic [1:0] rst_pipe_q;
   logic rst_sync_n;
   logic [7:0] line_drive_q;
   logic dclk_prev_q;
   logic dclk_rise;
   logic pop;
   logic fifo_valid;
   logic fifo_full;
   logic fifo_empty;
   logic [FW-1:0] fifo_out;
   logic [NUM_BUS*8-1:0] pop_data;
   logic [NUM_BUS-1:0] pop_pl;
   logic [NUM_BUS-1:0] pop_c1j1;
   logic [NUM_BUS-1:0] pop_ais;
   logic [NUM_BUS-1:0] par_calc;
   logic [NUM_LOWRATE-1:0] fp_sel;
   logic [7:0] data_pin_q;
   logic [NUM_BUS-1:0] par_pin_q;
   logic [NUM_BUS-1:0] alm_pin_q;
   logic [7:0] rdata_q;

   // Reset release through two stages so every flop leaves reset together
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe_q <= 2'h0;
      else if (clk_en)
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
   end
   assign rst_sync_n = rst_pipe_q[1];

   // Buffer between the framer stream and the drop clock
   rdm_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_sync_n),
      .clk_en(clk_en),
      .in_valid(src_valid),
      .in_ready(src_ready),
      .in_data({src_ais, src_c1j1, src_payload, src_data}),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_out),
      .full(fifo_full),
      .empty(fifo_empty)
   );
   assign {pop_ais, pop_c1j1, pop_pl, pop_data} = fifo_out;

   // Drop clock is sampled as a level; a byte is taken only on its rise
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         dclk_prev_q <= 1'b0;
      else if (clk_en)
         dclk_prev_q <= drop_bus_clock_ch0;
   end
   assign dclk_rise = drop_bus_clock_ch0 && !dclk_prev_q;
   // No channel enabled means no drain, so the buffer back-pressures
   assign pop = dclk_rise && fifo_valid && (|drop_bus_enable) && clk_en;

   // Parity per lane; even parity is the plain XOR of the covered bits
   for (genvar c = 0; c < NUM_BUS; c++)
   begin : g_par
      assign par_calc[c] = parity_odd_sel ^ (^pop_data[c*8 +: 8])
         ^ (parity_cover_ind & (pop_pl[c] ^ pop_c1j1[c]));
   end

   // Each low-rate channel offers the pulse of its own mode
   assign fp_sel = (lowrate_sts1_mode & tx_lowrate_sonet_frame_pulse)
      | (~lowrate_sts1_mode & egress_lowrate_frame_pulse);

   // Data pins: byte on the drop bus, or a software level on bit 0
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         data_pin_q <= 8'h00;
      else if (clk_en)
      begin
         if (drop_bus_enable[0])
         begin
            if (pop)
               data_pin_q <= pop_data[7:0];
         end
         else
            data_pin_q <= {7'h00, line_drive_q[rdm_pkg::GPO_BIT]};
      end
   end

   // Parity and alarm pins follow the bus enable of their channel
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         par_pin_q <= '0;
         alm_pin_q <= '0;
      end
      else if (clk_en)
      begin
         for (int c = 0; c < NUM_BUS; c++)
         begin
            if (drop_bus_enable[c])
            begin
               if (pop)
                  par_pin_q[c] <= par_calc[c];
               if (dclk_rise)
                  alm_pin_q[c] <= pop && pop_ais[c];
            end
            else
            begin
               par_pin_q[c] <= fp_sel[rdm_pkg::PARITY_LOWRATE_BASE + c];
               alm_pin_q[c] <= fp_sel[rdm_pkg::ALARM_LOWRATE_BASE + c];
            end
         end
      end
   end

   assign drop_bus_data_ch0 = data_pin_q;
   assign drop_bus_parity_out = par_pin_q;
   assign drop_bus_alarm_out = alm_pin_q;

   // Line drive register; only bit 2 steers a pin, the rest is scratch
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         line_drive_q <= rdm_pkg::LINE_DRIVE_RESET;
      else if (clk_en && reg_wr && reg_addr == rdm_pkg::LINE_DRIVE_OFFSET)
         line_drive_q <= reg_wdata;
   end

   // Read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         rdata_q <= 8'h00;
      else if (clk_en && reg_rd)
      begin
         case (reg_addr)
            rdm_pkg::LINE_DRIVE_OFFSET: rdata_q <= line_drive_q;
            rdm_pkg::STATUS_OFFSET:
               rdata_q <= {2'h0, 4'(drop_bus_enable), fifo_full, fifo_empty};
            default: rdata_q <= 8'h00;
         endcase
      end
   end
   assign reg_rdata = rdata_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_sync_n);

   a_alarm_ais_byte: assert property (
      (drop_bus_enable[0] && dclk_rise && clk_en) |=> (drop_bus_alarm_out[0] ==
         ($past(pop) && $past(pop_ais[0]))))
      else $error("alarm pin does not match AIS flag of byte");
   a_ds3_frame_pulse: assert property (
      (clk_en && !drop_bus_enable[0] && !lowrate_sts1_mode[0])
         |=> drop_bus_alarm_out[0] == $past(egress_lowrate_frame_pulse[0]))
      else $error("DS3/E3 frame pulse not on alarm pin");
   a_sts1_frame_pulse: assert property (
      (clk_en && !drop_bus_enable[0] && lowrate_sts1_mode[0])
         |=> drop_bus_alarm_out[0] == $past(tx_lowrate_sonet_frame_pulse[0]))
      else $error("STS-1 frame pulse not on alarm pin");
   a_data_hold: assert property (
      (drop_bus_enable[0] && !pop) |=> $stable(drop_bus_data_ch0))
      else $error("drop data changed without drop clock rise");
   a_data_lsb: assert property (
      (drop_bus_enable[0] && pop) |=> drop_bus_data_ch0 == $past(pop_data[7:0]))
      else $error("drop byte not presented in bit order");
   a_gpo_follow: assert property (
      (clk_en && !drop_bus_enable[0])
         |=> drop_bus_data_ch0 == {7'h00, $past(line_drive_q[2])})
      else $error("bit 0 does not follow line drive bit 2");
   a_parity_fallback: assert property (
      (clk_en && !drop_bus_enable[1]) |=> drop_bus_parity_out[1] == $past(fp_sel[5]))
      else $error("parity pin 1 does not carry channel 5 pulse");
   a_parity_value: assert property (
      (drop_bus_enable[2] && pop) |=> drop_bus_parity_out[2] ==
         ($past(parity_odd_sel) ^ (^$past(pop_data[23:16]))
         ^ ($past(parity_cover_ind) & ($past(pop_pl[2]) ^ $past(pop_c1j1[2])))))
      else $error("parity pin carries wrong parity");
   a_parity_aligned: assert property (
      (drop_bus_enable[3] && $past(drop_bus_enable[3]) && $changed(drop_bus_parity_out[3]))
         |-> $past(pop))
      else $error("parity changed apart from its byte");
endmodule

`default_nettype wire

// ---- inc/rdm_pkg.sv ----
/*
 Constants shared by the drop-bus pin sharing block: register offsets,
 reset values, channel counts and pin-to-channel mapping.
 Assumes it is compiled before every design file that names it.
*/
`default_nettype none
package rdm_pkg;
   // Register map, byte addresses on the microprocessor port
   localparam logic [15:0] LINE_DRIVE_OFFSET = 16'h1F80;
   localparam logic [15:0] STATUS_OFFSET = 16'h1F81;
   localparam logic [7:0] LINE_DRIVE_RESET = 8'h00;
   localparam int GPO_BIT = 2;
   // Channel counts and the low-rate channel each shared pin falls back to
   localparam int NUM_BUS = 4;
   localparam int NUM_LOWRATE = 8;
   localparam int PARITY_LOWRATE_BASE = 4;
   localparam int ALARM_LOWRATE_BASE = 0;
   // Buffer shape: per bus channel one byte plus payload, C1/J1 and AIS flags
   localparam int BYTE_W = 8;
   localparam int FIFO_W = NUM_BUS * (BYTE_W + 3);
   localparam int FIFO_DEPTH = 32;
endpackage
`default_nettype wire

// ---- test/rdm_drop_sink.sv ----
/*
 Drop-side sink model: makes the drop clock and captures each byte time.
 Assumes sys_clk is the block's clock and that the pins settle at its edges.
*/
`timescale 1ns/1ns
`default_nettype none
module rdm_drop_sink (
   // Clock and control
   input wire logic sys_clk,
   input wire logic run,
   // Drop bus pins
   output logic drop_clk,
   input wire logic [7:0] data,
   input wire logic [3:0] parity,
   input wire logic [3:0] alarm,
   // Captured byte time
   output logic cap_valid,
   output logic [7:0] cap_data,
   output logic [3:0] cap_par,
   output logic [3:0] cap_alarm
);
   logic [1:0] cnt_q = 2'h0;
   logic go;
   // Clock holds its level while stalled; capture late in the high phase
   // Run is taken at the edge itself so a bench change just after it cannot race
   always @(posedge sys_clk)
   begin
      go = run;
      #1;
      cap_valid = go && (cnt_q == 2'h3);
      cap_data = data; // Bit 0 taken as the LSB
      cap_par = parity;
      cap_alarm = alarm;
      if (go)
         cnt_q = cnt_q + 2'h1;
   end
   assign drop_clk = cnt_q[1];
   // Frame pulse pins are observed only, never fed to a line unit
endmodule
`default_nettype wire

// ---- test/rdm_drop_pin_mux_test.sv ----
/*
 Self-checking bench for the drop-bus pin sharing block.
 Assumes a 50 MHz sys_clk and the sink model on the drop bus pins.
*/
`timescale 1ns/1ns
`default_nettype none
module rdm_drop_pin_mux_test;
   localparam int DEPTH = 4;
   logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
   logic par_odd = 1'b0, par_cov = 1'b0, src_valid = 1'b0, src_ready, drop_clk, cap_valid;
   logic [15:0] reg_addr = 16'h0000, lfsr = 16'h0137, r;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, mode = 8'h00, eg_fp = 8'h00, tx_fp = 8'h00;
   logic [7:0] drop_data, cap_data, v, ld;
   logic [3:0] enable = 4'h0, s_pl = 4'h0, s_c1 = 4'h0, s_ais = 4'h0, drop_par, drop_alarm;
   logic [3:0] cap_par, cap_alarm, e_par, e_al, p;
   logic [31:0] src_data = 32'h0000_0000;
   logic [43:0] w, word_q[$];
   int n_fail = 0;
   int comparisons = 0;

   rdm_drop_pin_mux #(.FIFO_DEPTH(DEPTH)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .drop_bus_enable(enable), .lowrate_sts1_mode(mode),
      .parity_odd_sel(par_odd), .parity_cover_ind(par_cov),
      .egress_lowrate_frame_pulse(eg_fp), .tx_lowrate_sonet_frame_pulse(tx_fp),
      .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
      .src_payload(s_pl), .src_c1j1(s_c1), .src_ais(s_ais),
      .drop_bus_clock_ch0(drop_clk), .drop_bus_data_ch0(drop_data),
      .drop_bus_parity_out(drop_par), .drop_bus_alarm_out(drop_alarm));

   rdm_drop_sink sink_u (.sys_clk(sys_clk), .run(run), .drop_clk(drop_clk),
      .data(drop_data), .parity(drop_par), .alarm(drop_alarm), .cap_valid(cap_valid),
      .cap_data(cap_data), .cap_par(cap_par), .cap_alarm(cap_alarm));

   // Free-running 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   function logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   // Even parity is the XOR of covered bits; odd inverts it
   function logic par(input logic [7:0] d, input logic pl, input logic c1);
      return ^d ^ (par_cov & (pl ^ c1)) ^ par_odd;
   endfunction

   task check_reg(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t register read got %h exp %h", $time, got, exp);
      end
   endtask

   task check_pin(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t pin value got %h exp %h", $time, got, exp);
      end
   endtask

   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1 reg_wr = 1'b0;
   endtask

   task rd(input logic [15:0] a);
      @(posedge sys_clk);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1 reg_rd = 1'b0;
      v = reg_rdata;
   endtask

   task finish_test();
      $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Cuts a hang short; the whole run needs a few microseconds
   initial
   begin
      #100000;
      n_fail++;
      finish_test();
   end

   // Main sequence: registers, pin fallback, then the buffered drop stream
   initial
   begin
      repeat (10) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(rdm_pkg::LINE_DRIVE_OFFSET);
      check_reg(v, rdm_pkg::LINE_DRIVE_RESET);
      wr(rdm_pkg::STATUS_OFFSET, 8'hFF);
      rd(rdm_pkg::STATUS_OFFSET);
      check_reg(v, 8'h01);
      rd(16'h1F82);
      check_reg(v, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         ld = k ? 8'hFB : 8'h04;
         wr(rdm_pkg::LINE_DRIVE_OFFSET, ld);
         rd(rdm_pkg::LINE_DRIVE_OFFSET);
         check_reg(v, ld);
         for (int i = 0; i < 24; i++)
         begin
            @(posedge sys_clk);
            #1;
            if (i > 0)
            begin
               check_pin({4'h0, drop_par}, {4'h0, e_par});
               check_pin({4'h0, drop_alarm}, {4'h0, e_al});
               check_pin(drop_data, {7'h00, ld[rdm_pkg::GPO_BIT]});
            end
            r = rnd();
            mode = r[7:0];
            eg_fp = r[15:8];
            r = rnd();
            tx_fp = r[7:0];
            e_par = (mode[7:4] & tx_fp[7:4]) | (~mode[7:4] & eg_fp[7:4]);
            e_al = (mode[3:0] & tx_fp[3:0]) | (~mode[3:0] & eg_fp[3:0]);
         end
      end
      // Fill while the sink stalls, holding the refused word
      enable = 4'hF;
      {par_odd, par_cov} = r[9:8];
      for (int i = 0; i < DEPTH + 2; i++)
      begin
         r = rnd();
         w[15:0] = r;
         r = rnd();
         w[31:16] = r;
         r = rnd();
         w[43:32] = r[11:0];
         src_data = w[31:0];
         {s_ais, s_c1, s_pl} = w[43:32];
         src_valid = 1'b1;
         if (!src_ready)
            break;
         word_q.push_back(w);
         @(posedge sys_clk);
         #1;
      end
      check_reg(8'(word_q.size()), 8'(DEPTH));
      rd(rdm_pkg::STATUS_OFFSET);
      check_reg(v, 8'h3E);
      run = 1'b1;
      for (int i = 0; i < 20 && !src_ready; i++)
         @(posedge sys_clk) #1;
      check_pin({7'h00, src_ready}, 8'h01);
      word_q.push_back(w);
      @(posedge sys_clk);
      #1 src_valid = 1'b0;
      // Drain every word, then one empty byte time; the sink is read mid-cycle
      @(negedge sys_clk);
      for (int n = 0; n <= DEPTH + 1; n++)
      begin
         for (int t = 0; t < 20 && cap_valid !== 1'b1; t++)
            @(negedge sys_clk);
         check_pin({7'h00, cap_valid}, 8'h01);
         if (n <= DEPTH)
         begin
            w = word_q.pop_front();
            for (int c = 0; c < 4; c++)
               p[c] = par(w[8*c+:8], w[32+c], w[36+c]);
            check_pin(cap_data, w[7:0]);
            check_pin({4'h0, cap_par}, {4'h0, p});
         end
         check_pin({4'h0, cap_alarm}, {4'h0, n <= DEPTH ? w[43:40] : 4'h0});
         // Step through all parity modes, one per byte, well before the next pop
         @(posedge sys_clk);
         #1 {par_odd, par_cov} = 2'(n);
         @(negedge sys_clk);
      end
      finish_test();
   end
endmodule
`default_nettype wire
